// ---- rtl/drive_status_outputs.sv ----
// module: drive status signal generation and terminal routing
//
// Operation
// (RULE_01) ready is on whenever the drive can operate, including running.
// (RULE_02) running is on at or above starting frequency; off stopped/braking.
// (RULE_03) code 11/111 routes ready; code 0/100 routes running.
// (RULE_04) stop: ready only; run: both; dc brake: ready; trip/shutoff: none.
// (RULE_05) restart: running off coasting, on restarting; ready drops on outage.
// (RULE_06) after reset terminal A carries running, non-inverted.
// (RULE_07) alarm is on whenever a protective function trips the drive.
// (RULE_08) alarm defaults to relay terminal; code 99/199 routes it elsewhere.
// (RULE_09) hardware fault from circuit failure or wiring; code 91/191.
// (RULE_10) hw fault causes: brake, ground, phase, storage, board, cpu, inrush.
// (RULE_11) ground fault shown as accel overcurrent still raises hardware fault.
// (RULE_12) up-to-frequency within percent band of set frequency, default 10.
// (RULE_13) code 1/101 routes up-to-frequency.
// (RULE_14) frequency detect at or above threshold, 0 to 400 Hz, default 6.
// (RULE_15) reverse threshold used in reverse unless it holds 9999.
// (RULE_16) frequency detect defaults to its terminal; code 4/104 elsewhere.
// (RULE_17) dc injection braking clears all frequency-related signals.
// (RULE_18) compare uses output frequency before slip compensation.
// (RULE_19) sensitivity and thresholds writable only when user group is 0.
// (RULE_20) codes 0-99 conduct when active; 100-199 conduct when inactive.
// (RULE_21) each terminal decodes function and polarity, drives selected flag.
`timescale 1ns/1ns
module drive_status_outputs #(
   parameter int FREQ_W = 16
) (
   input  wire logic                          mclk,         // control clock
   input  wire logic                          sys_rst,      // async reset
   input  wire logic [7:0]                    reg_addr,     // byte address
   input  wire logic [31:0]                   reg_wdata,    // write data
   input  wire logic                          reg_wr,       // write strobe
   input  wire logic                          reg_rd,       // read strobe
   output logic [31:0]                        reg_rdata,    // read data
   input  wire drive_status_pkg::drive_state_s drive_state, // drive state
   input  wire drive_status_pkg::fault_cause_s fault_cause, // fault causes
   input  wire logic [FREQ_W-1:0]             out_freq_raw, // pre slip comp
   input  wire logic [FREQ_W-1:0]             set_freq,     // set frequency
   output logic                               term_a,       // running term
   output logic                               term_b,       // freq det term
   output logic                               term_c        // relay contact
);

   // =====================================================================
   // configuration registers
   // =====================================================================
   logic [7:0]        sel_a_ff;
   logic [7:0]        sel_b_ff;
   logic [7:0]        sel_c_ff;
   logic [6:0]        sens_ff;
   logic [15:0]       fwd_thr_ff;
   logic [15:0]       rev_thr_ff;
   logic [15:0]       start_freq_ff;
   logic [7:0]        user_grp_ff;
   logic              param_wr_ok;
   drive_status_pkg::status_ind_s ind_ff;
   drive_status_pkg::status_ind_s nxt_ind;

   assign param_wr_ok = (user_grp_ff == drive_status_pkg::RST_USER_GRP); // RULE_19

   function automatic logic [15:0] clamp_thr(input logic [31:0] v);
      clamp_thr = (v[15:0] == drive_status_pkg::THR_SAME_AS_FWD) ? v[15:0] :
                  (v[31:16] != 16'h0000 || v[15:0] > drive_status_pkg::THR_MAX)
                  ? drive_status_pkg::THR_MAX : v[15:0];
   endfunction : clamp_thr

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sel_a_ff <= drive_status_pkg::RST_SEL_A;                   // RULE_06
         sel_b_ff <= drive_status_pkg::RST_SEL_B;                   // RULE_16
         sel_c_ff <= drive_status_pkg::RST_SEL_C;                   // RULE_08
         user_grp_ff   <= drive_status_pkg::RST_USER_GRP;
         start_freq_ff <= drive_status_pkg::RST_START_FREQ;
      end else if (reg_wr) begin
         unique case (reg_addr)
            drive_status_pkg::ADDR_SEL_A:      sel_a_ff <= reg_wdata[7:0];
            drive_status_pkg::ADDR_SEL_B:      sel_b_ff <= reg_wdata[7:0];
            drive_status_pkg::ADDR_SEL_C:      sel_c_ff <= reg_wdata[7:0];
            drive_status_pkg::ADDR_USER_GRP:   user_grp_ff <= reg_wdata[7:0];
            drive_status_pkg::ADDR_START_FREQ: start_freq_ff <= reg_wdata[15:0];
            default: ;
         endcase
      end
   end

   // =====================================================================
   // write-protected detection settings
   // =====================================================================
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sens_ff    <= drive_status_pkg::RST_SENS;                  // RULE_12
         fwd_thr_ff <= drive_status_pkg::RST_FWD_THR;               // RULE_14
         rev_thr_ff <= drive_status_pkg::THR_SAME_AS_FWD;
      end else if (reg_wr && param_wr_ok) begin                     // RULE_19
         if (reg_addr == drive_status_pkg::ADDR_SENS) begin
            sens_ff <= (reg_wdata[6:0] > drive_status_pkg::SENS_MAX ||
                        reg_wdata[31:7] != 25'h0000000)
                       ? drive_status_pkg::SENS_MAX : reg_wdata[6:0];
         end
         if (reg_addr == drive_status_pkg::ADDR_FWD_THR) begin
            fwd_thr_ff <= (clamp_thr(reg_wdata) ==
                           drive_status_pkg::THR_SAME_AS_FWD)
                          ? drive_status_pkg::THR_MAX : clamp_thr(reg_wdata);
         end
         if (reg_addr == drive_status_pkg::ADDR_REV_THR) begin
            rev_thr_ff <= clamp_thr(reg_wdata);
         end
      end
   end

   // =====================================================================
   // status derivation
   // =====================================================================
   logic [15:0] det_thr;
   logic [FREQ_W+7:0] band;
   logic [FREQ_W+7:0] diff;
   logic [FREQ_W+7:0] scaled_diff;
   logic        shut;
   logic        hw_fault;

   always_comb begin
      // a ground fault shown as accel overcurrent still counts by its cause
      hw_fault = fault_cause.brake_transistor_fault |
                 fault_cause.output_ground_fault |                  // RULE_11
                 fault_cause.output_phase_loss |
                 fault_cause.param_storage_fault |
                 fault_cause.internal_board_fault |
                 fault_cause.cpu_fault |
                 fault_cause.inrush_limit_fault;                    // RULE_10
      det_thr = (drive_state.reverse &&
                 rev_thr_ff != drive_status_pkg::THR_SAME_AS_FWD)
                ? rev_thr_ff : fwd_thr_ff;                          // RULE_15
      // band compare in percent: |f - set| * 100 <= set * sens
      diff = (out_freq_raw >= set_freq)
             ? (FREQ_W+8)'(out_freq_raw - set_freq)
             : (FREQ_W+8)'(set_freq - out_freq_raw);                // RULE_18
      scaled_diff = (FREQ_W+8)'(diff * 8'h64);
      // widen before the product, a 16-bit product would wrap
      band = (FREQ_W+8)'(set_freq) * (FREQ_W+8)'(sens_ff);
      shut = drive_state.tripped | drive_state.shutoff;

      nxt_ind = '0;
      nxt_ind.trip_alarm_ind = drive_state.tripped;                 // RULE_07
      nxt_ind.hw_fault_ind   = hw_fault;                            // RULE_09
      nxt_ind.operation_ready_ind = !shut &&
                                    !drive_state.power_fail;        // RULE_01
      if (!shut && !drive_state.dc_brake && !drive_state.stopped &&
          !drive_state.restart_coast) begin                         // RULE_04
         nxt_ind.running_ind = (drive_state.running ||
                                drive_state.restarting) &&
                               (out_freq_raw >= start_freq_ff);     // RULE_02
      end
      if (drive_state.restarting && !shut) begin
         nxt_ind.running_ind = 1'b1;                                // RULE_05
      end
      // frequency flags suppressed while braking or shut off
      if (!drive_state.dc_brake && !shut) begin                     // RULE_17
         nxt_ind.up_to_freq_ind  = (set_freq != '0) &&
                                   (scaled_diff <= band);           // RULE_12
         nxt_ind.freq_detect_ind = (FREQ_W+8)'(out_freq_raw) >=
                                   (FREQ_W+8)'(det_thr);            // RULE_14
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ind_ff <= '0;
      end else begin
         ind_ff <= nxt_ind;
      end
   end

   // =====================================================================
   // terminal routing
   // =====================================================================
   terminal_route u_term_a (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .sel_code (sel_a_ff),
      .ind      (ind_ff),
      .term_out (term_a)                                            // RULE_03
   );

   terminal_route u_term_b (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .sel_code (sel_b_ff),
      .ind      (ind_ff),
      .term_out (term_b)                                            // RULE_13
   );

   terminal_route u_term_c (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .sel_code (sel_c_ff),
      .ind      (ind_ff),
      .term_out (term_c)                                            // RULE_08
   );

   // =====================================================================
   // read port
   // =====================================================================
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            drive_status_pkg::ADDR_SEL_A:      reg_rdata <= {24'h0, sel_a_ff};
            drive_status_pkg::ADDR_SEL_B:      reg_rdata <= {24'h0, sel_b_ff};
            drive_status_pkg::ADDR_SEL_C:      reg_rdata <= {24'h0, sel_c_ff};
            drive_status_pkg::ADDR_SENS:       reg_rdata <= {25'h0, sens_ff};
            drive_status_pkg::ADDR_FWD_THR:    reg_rdata <= {16'h0, fwd_thr_ff};
            drive_status_pkg::ADDR_REV_THR:    reg_rdata <= {16'h0, rev_thr_ff};
            drive_status_pkg::ADDR_START_FREQ: reg_rdata <= {16'h0, start_freq_ff};
            drive_status_pkg::ADDR_USER_GRP:   reg_rdata <= {24'h0, user_grp_ff};
            drive_status_pkg::ADDR_STATUS:     reg_rdata <= {26'h0, ind_ff};
            default:                           reg_rdata <= 32'h00000000;
         endcase
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

endmodule : drive_status_outputs

// ---- rtl/drive_status_pkg.sv ----
// package: constants and carriers for the drive status signal outputs
package drive_status_pkg;

   // =====================================================================
   // register map (byte addresses, one 32-bit register every 4 bytes)
   // =====================================================================
   localparam logic [7:0] ADDR_SEL_A      = 8'h00;
   localparam logic [7:0] ADDR_SEL_B      = 8'h04;
   localparam logic [7:0] ADDR_SEL_C      = 8'h08;
   localparam logic [7:0] ADDR_SENS       = 8'h0C;
   localparam logic [7:0] ADDR_FWD_THR    = 8'h10;
   localparam logic [7:0] ADDR_REV_THR    = 8'h14;
   localparam logic [7:0] ADDR_START_FREQ = 8'h18;
   localparam logic [7:0] ADDR_USER_GRP   = 8'h1C;
   localparam logic [7:0] ADDR_STATUS     = 8'h20;

   // =====================================================================
   // selection codes
   // =====================================================================
   localparam logic [7:0] CODE_RUN      = 8'h00;
   localparam logic [7:0] CODE_SU       = 8'h01;
   localparam logic [7:0] CODE_FU       = 8'h04;
   localparam logic [7:0] CODE_READY    = 8'h0B;
   localparam logic [7:0] CODE_HWFAULT  = 8'h5B;
   localparam logic [7:0] CODE_ALARM    = 8'h63;
   localparam logic [7:0] CODE_INV_BASE = 8'h64;
   localparam logic [7:0] CODE_INV_MAX  = 8'hC7;

   // =====================================================================
   // reset values (frequencies in 0.01 Hz, sensitivity in percent)
   // =====================================================================
   localparam logic [7:0]  RST_SEL_A      = 8'h00;
   localparam logic [7:0]  RST_SEL_B      = 8'h04;
   localparam logic [7:0]  RST_SEL_C      = 8'h63;
   localparam logic [6:0]  RST_SENS       = 7'h0A;
   localparam logic [6:0]  SENS_MAX       = 7'h64;
   localparam logic [15:0] RST_FWD_THR    = 16'h0258;
   localparam logic [15:0] THR_MAX        = 16'h9C40;
   localparam logic [15:0] THR_SAME_AS_FWD = 16'h270F;
   localparam logic [15:0] RST_START_FREQ = 16'h0032;
   localparam logic [7:0]  RST_USER_GRP   = 8'h00;

   typedef struct packed {
      logic stopped;
      logic running;
      logic dc_brake;
      logic tripped;
      logic shutoff;
      logic restart_coast;
      logic restarting;
      logic power_fail;
      logic reverse;
   } drive_state_s;

   typedef struct packed {
      logic brake_transistor_fault;
      logic output_ground_fault;
      logic output_phase_loss;
      logic param_storage_fault;
      logic internal_board_fault;
      logic cpu_fault;
      logic inrush_limit_fault;
      logic accel_overcurrent_trip;
   } fault_cause_s;

   typedef struct packed {
      logic operation_ready_ind;
      logic running_ind;
      logic trip_alarm_ind;
      logic hw_fault_ind;
      logic up_to_freq_ind;
      logic freq_detect_ind;
   } status_ind_s;

endpackage : drive_status_pkg

// ---- rtl/terminal_route.sv ----
// module: one configurable output terminal, code decode and polarity
`timescale 1ns/1ns
module terminal_route (
   input  wire logic                             mclk,     // control clock
   input  wire logic                             sys_rst,  // async reset
   input  wire logic [7:0]                       sel_code, // selection code
   input  wire drive_status_pkg::status_ind_s    ind,      // internal flags
   output logic                                  term_out  // conducts when 1
);
   logic [7:0] base_code;
   logic       invert;
   logic       func_val;

   // =====================================================================
   // decode code into function index and polarity
   // =====================================================================
   always_comb begin
      invert    = (sel_code >= drive_status_pkg::CODE_INV_BASE) &&
                  (sel_code <= drive_status_pkg::CODE_INV_MAX);     // RULE_20
      base_code = invert ? sel_code - drive_status_pkg::CODE_INV_BASE
                         : sel_code;                                // RULE_21
      unique case (base_code)
         drive_status_pkg::CODE_RUN:     func_val = ind.running_ind;
         drive_status_pkg::CODE_SU:      func_val = ind.up_to_freq_ind;
         drive_status_pkg::CODE_FU:      func_val = ind.freq_detect_ind;
         drive_status_pkg::CODE_READY:   func_val = ind.operation_ready_ind;
         drive_status_pkg::CODE_HWFAULT: func_val = ind.hw_fault_ind;
         drive_status_pkg::CODE_ALARM:   func_val = ind.trip_alarm_ind;
         // unsupported codes: no function; terminal idles off, but conducts for codes 100-199
         default:                        func_val = 1'b0;
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         term_out <= 1'b0;
      end else begin
         term_out <= func_val ^ invert;                             // RULE_21
      end
   end
endmodule : terminal_route

// ---- tb/drive_status_properties.sv ----
// checker: terminal behaviour of the drive status outputs at the ports
`timescale 1ns/1ns
module drive_status_properties #(
   parameter int FREQ_W = 16
) (
   input wire logic                           mclk,         // control clock
   input wire logic                           sys_rst,      // async reset
   input wire logic [7:0]                     reg_addr,     // byte address
   input wire logic [31:0]                    reg_wdata,    // write data
   input wire logic                           reg_wr,       // write strobe
   input wire logic                           reg_rd,       // read strobe
   input wire logic [31:0]                    reg_rdata,    // read data
   input wire drive_status_pkg::drive_state_s drive_state,  // drive state
   input wire drive_status_pkg::fault_cause_s fault_cause,  // fault causes
   input wire logic [FREQ_W-1:0]              out_freq_raw, // output freq
   input wire logic [FREQ_W-1:0]              set_freq,     // set freq
   input wire logic                           term_a,       // terminal a
   input wire logic                           term_b,       // terminal b
   input wire logic                           term_c        // terminal c
);
   // =====================================================================
   // mirror of the selection codes, sel writes are never locked
   // =====================================================================
   logic [7:0] sel_a_ff;
   logic [7:0] sel_b_ff;
   logic [7:0] sel_c_ff;
   logic       quiet;
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sel_a_ff <= drive_status_pkg::RST_SEL_A;
         sel_b_ff <= drive_status_pkg::RST_SEL_B;
         sel_c_ff <= drive_status_pkg::RST_SEL_C;
      end else if (reg_wr) begin
         if (reg_addr == drive_status_pkg::ADDR_SEL_A) sel_a_ff <= reg_wdata[7:0];
         if (reg_addr == drive_status_pkg::ADDR_SEL_B) sel_b_ff <= reg_wdata[7:0];
         if (reg_addr == drive_status_pkg::ADDR_SEL_C) sel_c_ff <= reg_wdata[7:0];
      end
   end
   assign quiet = !drive_state.tripped && !drive_state.shutoff
                  && !drive_state.dc_brake;
   // =====================================================================
   // three stable cycles cover the indicator and terminal flops
   // =====================================================================
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   alarm_on_c_a: assert property (
      (sel_c_ff == 8'h63 && drive_state.tripped)[*3] |-> term_c)
      else $error("alarm terminal not conducting on trip");
   hw_fault_c_a: assert property (
      (sel_c_ff == 8'h5B && fault_cause.output_ground_fault)[*3] |-> term_c)
      else $error("hardware fault terminal not conducting");
   run_brake_off_a: assert property (
      (sel_a_ff == 8'h00 && drive_state.dc_brake)[*3] |-> !term_a)
      else $error("running terminal on during dc braking");
   run_shutoff_off_a: assert property (
      (sel_a_ff == 8'h00 && drive_state.shutoff)[*3] |-> !term_a)
      else $error("running terminal on during shutoff");
   restart_run_on_a: assert property (
      (sel_a_ff == 8'h00 && drive_state.restarting && quiet
       && !drive_state.power_fail)[*3] |-> term_a)
      else $error("running terminal off while restarting");
   ready_inverted_a: assert property (
      (sel_a_ff == 8'h6F && drive_state.running && quiet
       && !drive_state.power_fail)[*3] |-> !term_a)
      else $error("inverted ready terminal conducting while ready");
   su_inverted_a: assert property (
      (sel_a_ff == 8'h65 && quiet && out_freq_raw == set_freq
       && set_freq != '0)[*3] |-> !term_a)
      else $error("inverted up to frequency terminal conducting");
   fu_brake_off_a: assert property (
      (sel_b_ff == 8'h04 && drive_state.dc_brake)[*3] |-> !term_b)
      else $error("frequency detect terminal on during dc braking");
endmodule : drive_status_properties

// ---- tb/tb_top.sv ----
// testbench: drive status outputs, state table, routing and registers
`timescale 1ns/1ns
module tb_top;
   localparam int FREQ_W = 16;
   logic                           mclk, sys_rst, reg_wr, reg_rd;
   logic                           term_a, term_b, term_c;
   logic [7:0]                     reg_addr;
   logic [31:0]                    reg_wdata, reg_rdata, v;
   logic [15:0]                    out_freq_raw, set_freq;
   logic [2:0]                     levels;
   drive_status_pkg::drive_state_s drive_state;
   drive_status_pkg::fault_cause_s fault_cause;
   int                             err_count, samples_checked;

   drive_status_outputs #(.FREQ_W(FREQ_W)) dut_u (.mclk(mclk),
      .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .drive_state(drive_state), .fault_cause(fault_cause),
      .out_freq_raw(out_freq_raw), .set_freq(set_freq),
      .term_a(term_a), .term_b(term_b), .term_c(term_c));
   term_watcher watch_u (.mclk(mclk), .sys_rst(sys_rst), .term_a(term_a),
      .term_b(term_b), .term_c(term_c), .levels(levels));

   // =====================================================================
   // shared tasks
   // =====================================================================
   task automatic conclude;
      if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   // input edge -> status -> terminal -> watcher, one spare edge
   task automatic settle;
      repeat (4) @(posedge mclk);
      #1;
   endtask : settle
   task automatic drive(input logic [8:0] st, input logic [15:0] f,
                        input logic [7:0] fc);
      @(posedge mclk);
      drive_state <= st;
      out_freq_raw <= f;
      fault_cause <= fc;
      settle();
   endtask : drive

   // =====================================================================
   // scenarios
   // =====================================================================
   task automatic t_reset;
      logic [7:0]  a[9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
                            8'h18, 8'h1C, 8'h24};
      logic [31:0] e[9] = '{32'h0, 32'h4, 32'h63, 32'hA, 32'h258, 32'h270F,
                            32'h32, 32'h0, 32'h0};
      for (int i = 0; i < 9; i++) begin
         rd(a[i]);
         chk(v, e[i]);
      end
   endtask : t_reset
   task automatic t_states;
      logic [8:0]  st[8] = '{9'h100, 9'h080, 9'h0C0, 9'h020, 9'h090,
                             9'h008, 9'h004, 9'h00A};
      logic [15:0] f[8] = '{16'h0000, 16'h03E8, 16'h03E8, 16'h0000,
                            16'h03E8, 16'h0000, 16'h03E8, 16'h0000};
      logic [5:0]  e[8] = '{6'h20, 6'h33, 6'h20, 6'h08, 6'h00, 6'h20,
                            6'h33, 6'h00};
      for (int i = 0; i < 8; i++) begin
         drive(st[i], f[i], 8'h00);
         rd(drive_status_pkg::ADDR_STATUS);
         chk(v, {26'h0, e[i]});
         chk(levels, {e[i][4], e[i][0], e[i][3]});
      end
   endtask : t_states
   task automatic t_hwfault;
      wr(drive_status_pkg::ADDR_SEL_C, 32'h5B);
      for (int i = 0; i < 9; i++) begin
         drive(9'h100, 16'h0000, i < 8 ? 8'h01 << i : 8'h41);
         rd(drive_status_pkg::ADDR_STATUS);
         chk(v, {26'h0, 1'b1, 2'b00, i != 0, 2'b00});
         chk(levels[0], i != 0);
      end
      wr(drive_status_pkg::ADDR_SEL_C, 32'hBF);
      settle();
      chk(levels[0], 1'b0);
      wr(drive_status_pkg::ADDR_SEL_C, 32'h63);
      drive(9'h100, 16'h0000, 8'h00);
   endtask : t_hwfault
   task automatic t_codes;
      logic [7:0] c[6] = '{8'h00, 8'h01, 8'h04, 8'h0B, 8'h5B, 8'h63};
      logic       act[6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
      drive(9'h080, 16'h03E8, 8'h00);
      for (int i = 0; i < 12; i++) begin
         wr(drive_status_pkg::ADDR_SEL_A,
            {24'h0, c[i % 6] + (i >= 6 ? 8'h64 : 8'h00)});
         settle();
         chk(levels[2], act[i % 6] ^ (i >= 6));
      end
      wr(drive_status_pkg::ADDR_SEL_A, 32'h0);
   endtask : t_codes
   task automatic t_start;
      wr(drive_status_pkg::ADDR_START_FREQ, 32'h64);
      drive(9'h080, 16'h0063, 8'h00);
      chk(levels[2], 1'b0);
      drive(9'h080, 16'h0064, 8'h00);
      chk(levels[2], 1'b1);
   endtask : t_start
   task automatic t_su;
      logic [15:0] f[4] = '{16'h044C, 16'h044D, 16'h0384, 16'h0383};
      for (int i = 0; i < 4; i++) begin
         drive(9'h080, f[i], 8'h00);
         rd(drive_status_pkg::ADDR_STATUS);
         chk(v[1], i % 2 == 0);
      end
   endtask : t_su
   task automatic t_fu;
      logic [8:0]  st[7] = '{9'h080, 9'h080, 9'h081, 9'h081, 9'h081,
                             9'h081, 9'h080};
      logic [15:0] f[7] = '{16'h0258, 16'h0257, 16'h0257, 16'h0258,
                            16'h012C, 16'h012B, 16'h012C};
      logic        e[7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
      for (int i = 0; i < 7; i++) begin
         if (i == 4) wr(drive_status_pkg::ADDR_REV_THR, 32'h12C);
         drive(st[i], f[i], 8'h00);
         chk(levels[1], e[i]);
      end
   endtask : t_fu
   task automatic t_lock;
      wr(drive_status_pkg::ADDR_USER_GRP, 32'h1);
      wr(drive_status_pkg::ADDR_FWD_THR, 32'h64);
      rd(drive_status_pkg::ADDR_FWD_THR);
      chk(v, 32'h258);
      wr(drive_status_pkg::ADDR_USER_GRP, 32'h0);
      wr(drive_status_pkg::ADDR_FWD_THR, 32'h64);
      rd(drive_status_pkg::ADDR_FWD_THR);
      chk(v, 32'h64);
   endtask : t_lock

   // =====================================================================
   // clock, sequence and watchdog
   // =====================================================================
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 40'h0};
      {drive_state, fault_cause, out_freq_raw} = '0;
      set_freq = 16'h03E8;
      {err_count, samples_checked} = {32'h0, 32'h0};
      repeat (20) @(posedge mclk);
      sys_rst <= 1'b0;
      t_reset();
      t_states();
      t_hwfault();
      t_codes();
      t_start();
      t_su();
      t_fu();
      t_lock();
      conclude();
   end
   initial begin
      repeat (30000) @(posedge mclk);
      err_count++;
      conclude();
   end
endmodule : tb_top

bind drive_status_outputs drive_status_properties #(.FREQ_W(FREQ_W)) prop_u (
   .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .drive_state(drive_state),
   .fault_cause(fault_cause), .out_freq_raw(out_freq_raw),
   .set_freq(set_freq), .term_a(term_a), .term_b(term_b), .term_c(term_c));

// ---- tb/term_watcher.sv ----
// partner model: external equipment latching the output terminals
`timescale 1ns/1ns
module term_watcher (
   input  wire logic       mclk,    // control clock
   input  wire logic       sys_rst, // async reset
   input  wire logic       term_a,  // running terminal
   input  wire logic       term_b,  // freq detect terminal
   input  wire logic       term_c,  // relay contact
   output logic [2:0]      levels   // latched {a, b, c}
);
   // one scan flop, as a controller input card would see the contacts
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         levels <= 3'h0;
      end else begin
         levels <= {term_a, term_b, term_c};
      end
   end
endmodule : term_watcher
